// ===== bench/lcd_frame_timing_sleep_ctrl_bench.sv
// Self-checking bench for the frame timing and sleep control block
`timescale 1ns/1ps
module lcd_frame_timing_sleep_ctrl_bench;
   import lcd_timing_pkg::*;
   localparam int BC = 1;
   logic              CORE_CLK = 1'b0;
   logic              NRST = 1'b0;
   logic              psel, penable, pwrite, pready, pslverr, e;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, r;
   logic              rows_n, blank, lend, fend, cur, cur_ln, osc, hold, rel;
   logic [VW_W-1:0]   laddr;
   logic [BLOCKS-1:0] blk;
   int                n_mismatch = 0;
   int                total_checks = 0;
   int                c;
   int                k;
   int                lt[3][2] = '{'{0, 0}, '{255, 0}, '{2, 1}};
   // Source (3 = cursor), code, level, expected run length in frames
   int                ft[7][4] = '{'{3, 2, 1, 22}, '{3, 2, 0, 10},
      '{3, 3, 1, 44}, '{3, 3, 0, 20}, '{0, 2, 1, 16}, '{2, 3, 1, 2},
      '{1, 3, 0, 2}};
   always #25 CORE_CLK = ~CORE_CLK;
   lcd_frame_ctrl #(.BYTE_CLKS(BC)) i_lcd_frame_ctrl (
      .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .ROW_DRIVER_DISABLE_N(rows_n),
      .COLUMN_BLANK(blank), .LINE_END(lend), .FRAME_END(fend),
      .LINE_ADDR(laddr), .CURSOR_VISIBLE(cur), .CURSOR_WHOLE_LINE(cur_ln),
      .BLOCK_VISIBLE(blk), .OSC_RUN(osc), .MEM_CTRL_HOLD(hold),
      .HOST_BUS_RELEASE(rel));
   lcd_host_model i_lcd_host_model (
      .clk(CORE_CLK), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
      total_checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("[FAIL] %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      i_lcd_host_model.xfer(1'b1, a, d, r, e);
      chk(32'(e), 32'h0);
      #1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
      i_lcd_host_model.xfer(1'b0, a, '0, r, e);
      chk(r, x);
   endtask
   // Returns just after the first edge sampled with the line or frame end strobe high, the edge on which the line or frame ends
   task automatic wait_end(input bit ln, output int n);
      n = 0;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while ((ln ? lend : fend) !== 1'b1 && n < 4000);
      #1;
   endtask
   function automatic logic vis(input int s);
      return (s == 3) ? cur : blk[s];
   endfunction
   // Length of the next complete run at level v, sampled once per frame
   task automatic run_len(input int s, input logic v, output int len);
      int n;
      int g;
      g = 0;
      len = 0;
      do begin
         wait_end(1'b0, n);
         g++;
      end while (vis(s) === v && g < 300);
      do begin
         wait_end(1'b0, n);
         g++;
      end while (vis(s) !== v && g < 300);
      do begin
         len++;
         wait_end(1'b0, n);
         g++;
      end while (vis(s) === v && g < 300);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #(20000 * 50);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge CORE_CLK);
      NRST <= 1'b1;
      #1;
      chk(32'({rows_n, blank, osc, hold, rel, cur, blk}), 32'h1c0);
      for (k = 0; k < 6; k++) begin
         rd(ADDR_W'(4 * k), '0);
      end
      rd(OFF_STATUS, 32'h4);
      i_lcd_host_model.xfer(1'b0, 8'h1c, '0, r, e);
      chk({r[30:0], e}, 32'h1);
      i_lcd_host_model.xfer(1'b1, 8'h1c, '1, r, e);
      chk(32'(e), 32'h1);
      $display("test done: reset and map");
      foreach (lt[i]) begin
         wr(OFF_LINE_LEN, 32'(lt[i][0]));
         wr(OFF_FRAME_HT, 32'(lt[i][1]));
         rd(OFF_FRAME_HT, 32'(lt[i][1]));
         wait_end(1'b1, c);
         wait_end(1'b1, c);
         chk(32'(c), 32'((lt[i][0] + 1) * BC));
         wait_end(1'b0, c);
         wait_end(1'b0, c);
         chk(32'(c), 32'((lt[i][0] + 1) * (lt[i][1] + 1) * BC));
      end
      $display("test done: line and frame length");
      wr(OFF_VW_LOW, 32'h34);
      wr(OFF_VW_HIGH, 32'h12);
      wait_end(1'b0, c);
      chk(32'(laddr), 32'h0);
      wait_end(1'b1, c);
      chk(32'(laddr), 32'h1234);
      wait_end(1'b1, c);
      chk(32'(laddr), 32'h0);
      $display("test done: virtual width");
      wr(OFF_DISPLAY, 32'h105);
      chk(32'({blank, blk, cur, cur_ln}), 32'h06);
      wr(OFF_DISPLAY, 32'h255);
      chk(32'({blank, blk, cur, cur_ln}), 32'h21);
      wr(OFF_DISPLAY, 32'h104);
      chk(32'(cur), 32'h0);
      foreach (ft[i]) begin
         k = ft[i][0];
         wr(OFF_DISPLAY,
            32'h100 | (32'(ft[i][1]) << ((k == 3) ? 0 : 2 + 2 * k)));
         run_len(k, 1'(ft[i][2]), c);
         chk(32'(c), 32'(ft[i][3]));
      end
      wr(OFF_DISPLAY, 32'h102);
      run_len(3, 1'b1, c);
      wr(OFF_COMMAND, 32'(1) << CMD_MEMORY_WRITE_COMMAND_BIT);
      chk(32'(cur), 32'h1);
      $display("test done: display and flash");
      wr(OFF_DISPLAY, 32'h105);
      wr(OFF_COMMAND, 32'(1) << CMD_STANDBY_BIT);
      chk(32'({blank, rows_n}), 32'h3);
      k = 0;
      do begin
         wait_end(1'b0, c);
         k++;
      end while (rows_n !== 1'b0 && k < 4);
      chk(32'(k), 32'h2);
      chk(32'({osc, hold, rel}), 32'h3);
      k = 0;
      repeat (20) begin
         @(posedge CORE_CLK);
         if (lend !== 1'b0) k++;
      end
      chk(32'(k), 32'h0);
      rd(OFF_STATUS, 32'h7);
      wr(OFF_LINE_LEN, 32'h55);
      rd(OFF_LINE_LEN, 32'h2);
      wr(OFF_COMMAND, 32'(1) << CMD_WAKE_BIT);
      chk(32'({osc, rows_n, blank, laddr}), 32'h70000);
      rd(OFF_DISPLAY, 32'h005);
      wr(OFF_DISPLAY, 32'h105);
      chk(32'(blank), 32'h0);
      $display("test done: standby and wake");
      end_of_test();
   end
endmodule // lcd_frame_timing_sleep_ctrl_bench

// ===== bench/lcd_host_model.sv
// Host model: APB master that issues commands to the block
`timescale 1ns/1ps
module lcd_host_model (
   input  wire logic                              clk,
   output logic                                   psel,
   output logic                                   penable,
   output logic                                   pwrite,
   output logic      [lcd_timing_pkg::ADDR_W-1:0] paddr,
   output logic      [lcd_timing_pkg::DATA_W-1:0] pwdata,
   input  wire logic [lcd_timing_pkg::DATA_W-1:0] prdata,
   input  wire logic                              pready,
   input  wire logic                              pslverr
);
   import lcd_timing_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   // Idle address and data lines carry the inverse of the last transfer, so a stale bus
   // can never pass for a fresh request
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No wait limit here: only the bench watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule // lcd_host_model

// ===== logic/lcd_frame_ctrl.sv
// APB control core: frame timing, standby sequence, display and flash
`timescale 1ns/1ps

// Functional notes
// - Each scan line lasts line-length setting plus one byte periods.
// - Each frame holds frame-height setting plus one lines.
// - Sixteen-bit virtual width, low then high byte, steps line addresses.
// - Standby command carries no parameter byte.
// - After standby, at least one blank frame, then all operation stops.
// - Standby blanks column data and disables row drivers.
// - Row-driver disable falls one to two frames after standby.
// - Configuration registers keep their contents while asleep.
// - Memory control outputs hold their levels while asleep.
// - Setup command first byte wakes; host then sends display on.
// - Host bus lines are released while asleep.
// - Display switch command carries exactly one parameter byte.
// - Display-enable bit blanks everything and overrides block attributes.
// - Cursor field: off, steady, flash frame/32, flash frame/64.
// - Flashing cursor shows seventy percent of each period.
// - Cursor may flash over one character or a whole line.
// - Block field: blank, steady, flash frame/32, flash frame/4.
// - A memory write forces the cursor visible.
module lcd_frame_ctrl #(
   parameter int BYTE_CLKS = lcd_timing_pkg::BYTE_CLKS_DEFAULT
) (
   input  wire logic                              CORE_CLK,
   input  wire logic                              NRST,
   input  wire logic                              PSEL,
   input  wire logic                              PENABLE,
   input  wire logic                              PWRITE,
   input  wire logic [lcd_timing_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [lcd_timing_pkg::DATA_W-1:0] PWDATA,
   output logic      [lcd_timing_pkg::DATA_W-1:0] PRDATA,
   output logic                                   PREADY,
   output logic                                   PSLVERR,
   output logic                                   ROW_DRIVER_DISABLE_N,
   output logic                                   COLUMN_BLANK,
   output logic                                   LINE_END,
   output logic                                   FRAME_END,
   output logic      [lcd_timing_pkg::VW_W-1:0]   LINE_ADDR,
   output logic                                   CURSOR_VISIBLE,
   output logic                                   CURSOR_WHOLE_LINE,
   output logic      [lcd_timing_pkg::BLOCKS-1:0] BLOCK_VISIBLE,
   output logic                                   OSC_RUN,
   output logic                                   MEM_CTRL_HOLD,
   output logic                                   HOST_BUS_RELEASE
);
   import lcd_timing_pkg::*;

   generate
      if (BYTE_CLKS < 1) begin : g_bad_div
         $error("BYTE_CLKS must be at least 1");
      end
   endgenerate

   scan_if scan ();

   scan_timer #(
      .BYTE_CLKS (BYTE_CLKS)
   ) u_scan (
      .CORE_CLK (CORE_CLK),
      .NRST     (NRST),
      .scan     (scan.timer)
   );

   // Registers
   logic [PARAM_W-1:0]     line_len_q;
   logic [PARAM_W-1:0]     frame_ht_q;
   logic [VW_W-1:0]        vw_q;
   logic [DISP_W-1:0]      disp_q;
   sleep_st_t              st_q;
   sleep_st_t              st_d;
   logic                   seen_q;
   logic                   row_n_q;
   logic                   force_q;
   logic [FLASH_CNT_W-1:0] fcnt_q;
   logic [VW_W-1:0]        addr_q;
   logic [DATA_W-1:0]      prdata_q;
   logic                   pslverr_q;

   // Bus decode
   wire setup    = PSEL && !PENABLE;
   wire wr_acc   = PSEL && PENABLE && PWRITE;
   wire hit_len  = (PADDR == OFF_LINE_LEN);
   wire hit_ht   = (PADDR == OFF_FRAME_HT);
   wire hit_vwl  = (PADDR == OFF_VW_LOW);
   wire hit_vwh  = (PADDR == OFF_VW_HIGH);
   wire hit_disp = (PADDR == OFF_DISPLAY);
   wire hit_cmd  = (PADDR == OFF_COMMAND);
   wire hit_stat = (PADDR == OFF_STATUS);
   wire mapped   = hit_len || hit_ht || hit_vwl || hit_vwh || hit_disp
                   || hit_cmd || hit_stat;
   wire awake    = (st_q != ST_SLEEP);
   wire cfg_wr   = wr_acc && awake;

   // Command strobes; standby takes no parameter bytes at all
   wire cmd_wr      = wr_acc && hit_cmd;
   wire standby_cmd = cmd_wr && PWDATA[CMD_STANDBY_BIT];
   wire wake_cmd    = cmd_wr && PWDATA[CMD_WAKE_BIT];
   wire memory_write_command_cmd  = cmd_wr && PWDATA[CMD_MEMORY_WRITE_COMMAND_BIT] && awake;

   // Display register fields
   wire [FC_W-1:0] fc_field    = disp_q[DISP_FC_LSB +: FC_W];
   wire [FP_W-1:0] fp_field    = disp_q[DISP_FP_LSB +: FP_W];
   wire            disp_en     = disp_q[DISP_EN_BIT];
   wire            blank       = !disp_en || (st_q != ST_RUN);

   // Cursor flash decode
   logic cursor_on;
   wire  fast_on = fcnt_q[FLASH_CNT_W-2:0] <
                   (FLASH_CNT_W-1)'(CURSOR_ON_FAST);
   wire  slow_on = fcnt_q < FLASH_CNT_W'(CURSOR_ON_SLOW);
   always_comb begin
      case (attr_t'(fc_field))
         ATTR_BLANK:      cursor_on = 1'b0;
         ATTR_STEADY:     cursor_on = 1'b1;
         ATTR_FLASH_SLOW: cursor_on = fast_on || force_q;
         ATTR_FLASH_FAST: cursor_on = slow_on || force_q;
         default:         cursor_on = 1'b0;
      endcase
   end

   // Per-block attributes
   logic [BLOCKS-1:0] block_on;
   genvar gi;
   generate
      for (gi = 0; gi < BLOCKS; gi++) begin : g_block
         wire [1:0] attr = fp_field[2*gi +: 2];
         assign block_on[gi] =
            (attr_t'(attr) == ATTR_STEADY) ||
            ((attr_t'(attr) == ATTR_FLASH_SLOW) &&
             !fcnt_q[BLOCK_SLOW_BIT]) ||
            ((attr_t'(attr) == ATTR_FLASH_FAST) &&
             !fcnt_q[BLOCK_FAST_BIT]);
      end
   endgenerate

   // Read mux
   wire [STAT_W-1:0] status = {st_q == ST_DRAIN, CURSOR_VISIBLE, blank,
                               !row_n_q, st_q == ST_SLEEP};
   wire [DATA_W-1:0] rd_data =
      hit_len  ? DATA_W'(line_len_q) :
      hit_ht   ? DATA_W'(frame_ht_q) :
      hit_vwl  ? DATA_W'(vw_q[7:0]) :
      hit_vwh  ? DATA_W'(vw_q[15:8]) :
      hit_disp ? DATA_W'(disp_q) :
      hit_stat ? DATA_W'(status) : '0;

   // Standby sequence: the frame in progress is not counted, so the
   // second frame end marks at least one whole blank frame.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_RUN:   if (standby_cmd) st_d = ST_DRAIN;
         ST_DRAIN: if (scan.frame_end && seen_q) st_d = ST_SLEEP;
         ST_SLEEP: if (wake_cmd) st_d = ST_RUN;
         default:  st_d = ST_RUN;
      endcase
   end

   assign scan.run      = awake;
   assign scan.restart  = (st_q == ST_SLEEP) && wake_cmd;
   assign scan.line_len = line_len_q;
   assign scan.frame_ht = frame_ht_q;

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         st_q    <= ST_RUN;
         seen_q  <= 1'b0;
         row_n_q <= 1'b1;
      end else begin
         st_q    <= st_d;
         seen_q  <= (st_q == ST_DRAIN) && (seen_q || scan.frame_end);
         row_n_q <= (st_d != ST_SLEEP);
      end
   end

   // Configuration is frozen while asleep
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         line_len_q <= RST_LINE_LEN;
         frame_ht_q <= RST_FRAME_HT;
         vw_q       <= RST_VW;
      end else if (cfg_wr) begin
         if (hit_len) line_len_q <= PWDATA[PARAM_W-1:0];
         if (hit_ht)  frame_ht_q <= PWDATA[PARAM_W-1:0];
         if (hit_vwl) vw_q[7:0]  <= PWDATA[7:0];
         if (hit_vwh) vw_q[15:8] <= PWDATA[7:0];
      end
   end

   // One write of the display register is the whole switch command
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         disp_q <= RST_DISPLAY;
      end else if (cfg_wr && hit_disp) begin
         disp_q <= PWDATA[DISP_W-1:0];
      end else if (scan.restart) begin
         disp_q[DISP_EN_BIT] <= 1'b0;
      end
   end

   // Frame counter for flash; force set wins over its frame clear
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         fcnt_q  <= '0;
         force_q <= 1'b0;
      end else begin
         if (scan.frame_end) fcnt_q <= fcnt_q + 1'b1;
         if (memory_write_command_cmd) force_q <= 1'b1;
         else if (scan.frame_end) force_q <= 1'b0;
      end
   end

   // Start address of each line steps by the virtual width
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || scan.restart) begin
         addr_q <= '0;
      end else if (scan.frame_end) begin
         addr_q <= '0;
      end else if (scan.line_end) begin
         addr_q <= addr_q + vw_q;
      end
   end

   // Read data captured in setup so the answer needs no wait state
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= PWRITE ? '0 : rd_data;
         pslverr_q <= !mapped;
      end
   end

   assign PRDATA               = prdata_q;
   assign PREADY               = PSEL && PENABLE;
   assign PSLVERR              = PSEL && PENABLE && pslverr_q;
   assign ROW_DRIVER_DISABLE_N = row_n_q;
   assign COLUMN_BLANK         = blank;
   assign LINE_END             = scan.line_end;
   assign FRAME_END            = scan.frame_end;
   assign LINE_ADDR            = addr_q;
   assign CURSOR_VISIBLE       = cursor_on && !blank;
   assign CURSOR_WHOLE_LINE    = disp_q[DISP_LINE_BIT];
   assign BLOCK_VISIBLE        = blank ? '0 : block_on;
   assign OSC_RUN              = awake;
   assign MEM_CTRL_HOLD        = !awake;
   assign HOST_BUS_RELEASE     = !awake;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   sequence s_standby;
      st_q == ST_RUN && standby_cmd;
   endsequence

   sequence s_drain_done;
      st_q == ST_DRAIN && seen_q && scan.frame_end;
   endsequence

   property p_enter_sleep;
      s_drain_done |=> st_q == ST_SLEEP && !OSC_RUN && !ROW_DRIVER_DISABLE_N;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep)
      else $error("sleep not entered after blank frame");

   property p_standby_blank;
      s_standby |=> COLUMN_BLANK && ROW_DRIVER_DISABLE_N;
   endproperty
   a_standby_blank: assert property (p_standby_blank)
      else $error("standby did not blank columns at once");

   property p_rowdis_late;
      $fell(ROW_DRIVER_DISABLE_N) |-> $past(st_q) == ST_DRAIN && $past(seen_q);
   endproperty
   a_rowdis_late: assert property (p_rowdis_late)
      else $error("row drivers disabled too early");

   property p_cfg_hold;
      st_q == ST_SLEEP |=> $stable(line_len_q) && $stable(frame_ht_q)
                           && $stable(vw_q);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("configuration changed while asleep");

   property p_mem_hold;
      st_q == ST_SLEEP |-> MEM_CTRL_HOLD && HOST_BUS_RELEASE;
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory or bus lines not held in sleep");

   property p_wake;
      st_q == ST_SLEEP && wake_cmd |=> st_q == ST_RUN && COLUMN_BLANK
                                       && LINE_ADDR == '0;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not restart scan with display blank");

   property p_disp_override;
      !disp_en |-> BLOCK_VISIBLE == '0 && !CURSOR_VISIBLE;
   endproperty
   a_disp_override: assert property (p_disp_override)
      else $error("display off did not override attributes");

   property p_cursor_off;
      fc_field == 2'h0 |-> !CURSOR_VISIBLE;
   endproperty
   a_cursor_off: assert property (p_cursor_off)
      else $error("cursor shown while its field is off");

   property p_force;
      memory_write_command_cmd && fc_field != 2'h0 && !(cfg_wr && hit_disp)
         |=> cursor_on;
   endproperty
   a_force: assert property (p_force)
      else $error("memory write did not force the cursor on");

   property p_line_step;
      scan.line_end && !scan.frame_end && !scan.restart
         |=> LINE_ADDR == $past(addr_q) + $past(vw_q);
   endproperty
   a_line_step: assert property (p_line_step)
      else $error("line address did not step by virtual width");
endmodule // lcd_frame_ctrl

// ===== logic/lcd_timing_pkg.sv
// Shared constants and types for the frame timing and sleep control block
package lcd_timing_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PARAM_W = 8;
   localparam int VW_W = 16;
   localparam int DISP_W = 10;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFF_LINE_LEN    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_FRAME_HT    = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_VW_LOW      = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_VW_HIGH     = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_DISPLAY     = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_COMMAND     = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h18;

   // Reset values
   localparam logic [PARAM_W-1:0] RST_LINE_LEN   = 8'h00;
   localparam logic [PARAM_W-1:0] RST_FRAME_HT   = 8'h00;
   localparam logic [VW_W-1:0]    RST_VW         = 16'h0000;
   localparam logic [DISP_W-1:0]  RST_DISPLAY    = 10'h000;

   // Display register fields
   localparam int DISP_FC_LSB     = 0;
   localparam int FC_W            = 2;
   localparam int DISP_FP_LSB     = 2;
   localparam int BLOCKS          = 3;
   localparam int FP_W            = 2 * BLOCKS;
   localparam int DISP_EN_BIT     = 8;
   localparam int DISP_LINE_BIT   = 9;

   // Command register bits, write only
   localparam int CMD_STANDBY_BIT = 0;
   localparam int CMD_WAKE_BIT    = 1;
   localparam int CMD_MEMORY_WRITE_COMMAND_BIT  = 2;

   // Status register bits
   localparam int STAT_ASLEEP_BIT = 0;
   localparam int STAT_ROWDIS_BIT = 1;
   localparam int STAT_BLANK_BIT  = 2;
   localparam int STAT_CURSOR_BIT = 3;
   localparam int STAT_DRAIN_BIT  = 4;
   localparam int STAT_W          = 5;

   // Flash timing in frames
   localparam int FLASH_CNT_W        = 6;
   localparam int CURSOR_FAST_FRAMES = 32;
   localparam int CURSOR_SLOW_FRAMES = 64;
   localparam int CURSOR_DUTY_PCT    = 70;
   localparam int CURSOR_ON_FAST = CURSOR_FAST_FRAMES * CURSOR_DUTY_PCT / 100;
   localparam int CURSOR_ON_SLOW = CURSOR_SLOW_FRAMES * CURSOR_DUTY_PCT / 100;
   localparam int BLOCK_SLOW_FRAMES  = 32;
   localparam int BLOCK_FAST_FRAMES  = 4;
   localparam int BLOCK_SLOW_BIT     = $clog2(BLOCK_SLOW_FRAMES) - 1;
   localparam int BLOCK_FAST_BIT     = $clog2(BLOCK_FAST_FRAMES) - 1;

   // Clock periods per display byte period
   localparam int BYTE_CLKS_DEFAULT  = 4;

   typedef enum logic [1:0] {
      ATTR_BLANK,
      ATTR_STEADY,
      ATTR_FLASH_SLOW,
      ATTR_FLASH_FAST
   } attr_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_DRAIN,
      ST_SLEEP
   } sleep_st_t;
endpackage

// ===== logic/scan_if.sv
// Link between the control core and the scan counters
`timescale 1ns/1ps
interface scan_if;
   logic       run;
   logic       restart;
   logic [7:0] line_len;
   logic [7:0] frame_ht;
   logic       line_end;
   logic       frame_end;
   logic [7:0] line_idx;

   modport ctrl  (output run, restart, line_len, frame_ht,
                  input  line_end, frame_end, line_idx);
   modport timer (input  run, restart, line_len, frame_ht,
                  output line_end, frame_end, line_idx);
endinterface

// ===== logic/scan_timer.sv
// Byte, line and frame counters driven by the main oscillator
`timescale 1ns/1ps
module scan_timer #(
   parameter int BYTE_CLKS = lcd_timing_pkg::BYTE_CLKS_DEFAULT
) (
   input  wire logic CORE_CLK,
   input  wire logic NRST,
   scan_if.timer     scan
);
   import lcd_timing_pkg::*;

   localparam int DIV_W = (BYTE_CLKS > 1) ? $clog2(BYTE_CLKS) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BYTE_CLKS - 1);

   generate
      if (BYTE_CLKS < 1) begin : g_bad_div
         $error("BYTE_CLKS must be at least 1");
      end
   endgenerate

   logic [DIV_W-1:0]   div_q;
   logic [PARAM_W-1:0] byte_q;
   logic [PARAM_W-1:0] line_q;
   wire                byte_en  = scan.run && (div_q == DIV_LAST);
   wire                last_byte = (byte_q == scan.line_len);
   wire                last_line = (line_q == scan.frame_ht);

   assign scan.line_end  = byte_en && last_byte;
   assign scan.frame_end = scan.line_end && last_line;
   assign scan.line_idx  = line_q;

   // Restart wins so a wake always begins at the top of a frame
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || scan.restart) begin
         div_q  <= '0;
         byte_q <= '0;
         line_q <= '0;
      end else if (scan.run) begin
         div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
         if (byte_en) begin
            byte_q <= last_byte ? '0 : byte_q + 1'b1;
            if (last_byte) begin
               line_q <= last_line ? '0 : line_q + 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   property p_line_len;
      scan.line_end |-> byte_q == scan.line_len && byte_en;
   endproperty
   a_line_len: assert property (p_line_len)
      else $error("line ended before its programmed length");

   property p_frame_ht;
      scan.frame_end |-> scan.line_end && line_q == scan.frame_ht;
   endproperty
   a_frame_ht: assert property (p_frame_ht)
      else $error("frame ended on the wrong line");

   property p_halt;
      !scan.run && !scan.restart |=> $stable(byte_q) && $stable(line_q);
   endproperty
   a_halt: assert property (p_halt)
      else $error("scan counters moved while stopped");
endmodule // scan_timer
